//--- verilog/lsm_defines.svh
// Purpose: Constants of the logger scratchpad and mission control
// Assumes: Included by the design module
// Notes: Constants only, no logic
`ifndef LSM_DEFINES_SVH
`define LSM_DEFINES_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define LSM_CMD_WR 8'h0f
`define LSM_CMD_RD 8'haa
`define LSM_CMD_CP 8'h99

// ----------------------------------------
// Scratchpad and status fields
// ----------------------------------------
`define LSM_OFF_LAST 5'h1f
`define LSM_BIT_LAST 3'h7
`define LSM_CRC_INIT 16'h0000
`define LSM_CRC_POLY 16'ha001
`define LSM_ONES 8'hff
`define LSM_ALT 8'h55
`define LSM_ZERO 8'h00

// ----------------------------------------
// Address ranges
// ----------------------------------------
`define LSM_REG_LO 16'h0200
`define LSM_REG_HI 16'h023f
`define LSM_PW_LO 16'h0228
`define LSM_PW_HI 16'h0237

// ----------------------------------------
// Time base
// ----------------------------------------
`define LSM_SEC_LAST 6'h3b

`endif

//--- verilog/lsm_pkg.sv
// Purpose: Types of the logger scratchpad and mission control
// Assumes: Constants come from lsm_defines.svh
// Notes: Structs carry grouped signals
package lsm_pkg;

   typedef struct packed {
      logic [13:0] rate;
      logic fast;
      logic start_on_alarm;
      logic logging_enable;
      logic [15:0] delay;
   } lsm_cfg_t;

   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [7:0] data;
   } lsm_wr_t;

   typedef enum logic [3:0] {
      C_CMD, C_WA1, C_WA2, C_WDAT, C_RHDR, C_RDAT, C_CRC, C_ONES,
      C_CA1, C_CA2, C_CES, C_COPY, C_ALT, C_HALT
   } lsm_cst_t;

   typedef enum logic [2:0] {M_OFF, M_DLY, M_WAIT, M_ARM, M_RUN} lsm_mst_t;

endpackage

//--- verilog/lsm_ctl.sv
// Purpose: Scratchpad commands and mission sequencing of a temp logger
// Assumes: Link layer on clk_i delivers bits, slots and reset pulses
// Notes: Password checks and other commands live outside
//
// Summary of operation
// - Sample spacing in seconds or minutes
// - Start sets mission active, clears memory flag
// - After delay stamp, log, bump both counters
// - Later entries follow the sample period
// - Alarm start: measure, bump device counter only
// - Alarm stamps; log one period later
// - General memory writable, all readable always
// - Password locations read as zero
// - Status byte: offset, partial flag, zero, accepted
// - Copy only with ending offset 1Fh
// - Low five address bits give byte offset
// - Accepted flag set by copy, cleared by write
// - Status read only, addresses loaded by commands
// - Write command; partial last byte sets flag
// - Write CRC over command, address, data
// - Read sends address, status, data, CRC
// - Ones after read CRC until reset
// - Copy needs the three bytes read back
// - Copy into register pages fails in mission
// - Regular speed until overdrive is selected
// - Internal accesses beat serial accesses in mission
// - Authorization bytes must match address and status
`timescale 1ns/1ps
`include "lsm_defines.svh"

module lsm_ctl #(
   parameter int CNT_W = 24
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic bus_rst_i,
   input wire logic od_set_i,
   input wire logic rx_vld_i,
   input wire logic rx_bit_i,
   input wire logic rd_slot_i,
   input wire lsm_pkg::lsm_cfg_t cfg_i,
   input wire logic start_cmd_i,
   input wire logic stop_cmd_i,
   input wire logic clr_mem_i,
   input wire logic sec_tick_i,
   input wire logic temp_alarm_i,
   input wire logic int_busy_i,
   input wire logic [15:0] ext_addr_i,
   input wire logic [7:0] ext_data_i,
   output logic rd_bit_o,
   output logic overdrive_speed_sel_o,
   output logic mission_active_o,
   output logic memory_cleared_flag_o,
   output logic stamp_o,
   output logic log_o,
   output logic measure_o,
   output logic [CNT_W-1:0] mission_cnt_o,
   output logic [CNT_W-1:0] dev_cnt_o,
   output logic [7:0] ext_data_o,
   output lsm_pkg::lsm_wr_t cp_o
);
   import lsm_pkg::*;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
      logic [15:0] s;
      s = {1'b0, c[15:1]};
      if (c[0] ^ b) begin
         s = s ^ `LSM_CRC_POLY;
      end
      return s;
   endfunction

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] s;
      s = c;
      for (int i = 0; i < 8; i++) begin
         s = crc_bit(s, d[i]);
      end
      return s;
   endfunction

   function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   lsm_cst_t cst_r;
   lsm_mst_t mst_r;
   logic [7:0] sp_r [32];
   logic [7:0] rx_sr_r;
   logic [2:0] rx_n_r;
   logic [7:0] tx_sr_r;
   logic [2:0] tx_n_r;
   logic [1:0] hdr_n_r;
   logic crc_n_r;
   logic [15:0] crc_r;
   logic [4:0] ptr_r;
   logic [7:0] ta_lo_r;
   logic [7:0] ta_hi_r;
   logic [4:0] es_off_r;
   logic pf_r;
   logic aa_r;
   logic auth_ok_r;
   logic od_r;
   lsm_wr_t cp_r;
   logic [7:0] ext_r;
   logic mip_r;
   logic memory_cleared_flag_r;
   logic stamp_r;
   logic log_r;
   logic meas_r;
   logic [CNT_W-1:0] mcnt_r;
   logic [CNT_W-1:0] dcnt_r;
   logic [5:0] sec_n_r;
   logic [13:0] per_n_r;
   logic [15:0] dly_n_r;

   logic [7:0] rx_byte;
   logic byte_done;
   logic [7:0] es_byte;
   logic [15:0] crc_w;
   logic [15:0] crc_tx;
   logic tx_st;
   logic tx_last;
   logic min_tick;
   logic unit_tick;
   logic samp_tick;

   assign rx_byte = {rx_bit_i, rx_sr_r[7:1]};
   assign byte_done = rx_vld_i && (rx_n_r == `LSM_BIT_LAST);
   assign es_byte = {aa_r, 1'b0, pf_r, es_off_r};
   assign crc_w = crc_byte(crc_r, rx_byte);
   assign crc_tx = crc_bit(crc_r, tx_sr_r[0]);
   assign tx_st = cst_r inside {C_RHDR, C_RDAT, C_CRC, C_ONES, C_ALT};
   assign tx_last = rd_slot_i && (tx_n_r == `LSM_BIT_LAST);

   // ----------------------------------------
   // Byte assembly, first bit is bit 0
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_sr_r <= `LSM_ZERO;
         rx_n_r <= 3'h0;
      end else if (bus_rst_i) begin
         rx_n_r <= 3'h0;
      end else if (rx_vld_i) begin
         rx_sr_r <= rx_byte;
         rx_n_r <= 3'(rx_n_r + 3'h1);
      end
   end

   // ----------------------------------------
   // Scratchpad storage
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (cst_r == C_WDAT && byte_done && !bus_rst_i) begin
         sp_r[ptr_r] <= rx_byte;
      end
   end

   // ----------------------------------------
   // Command sequencing
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cst_r <= C_CMD;
         tx_sr_r <= `LSM_ONES;
         tx_n_r <= 3'h0;
         hdr_n_r <= 2'h0;
         crc_n_r <= 1'b0;
         crc_r <= `LSM_CRC_INIT;
         ptr_r <= 5'h00;
         ta_lo_r <= `LSM_ZERO;
         ta_hi_r <= `LSM_ZERO;
         es_off_r <= 5'h00;
         pf_r <= 1'b0;
         aa_r <= 1'b0;
         auth_ok_r <= 1'b0;
         cp_r <= '0;
      end else if (bus_rst_i && cst_r != C_COPY) begin
         cst_r <= C_CMD;
         tx_sr_r <= `LSM_ONES;
         tx_n_r <= 3'h0;
         cp_r.we <= 1'b0;
         if (cst_r == C_WDAT && rx_n_r != 3'h0) begin
            pf_r <= 1'b1;
         end
      end else begin
         cp_r.we <= 1'b0;
         if (rd_slot_i && tx_st) begin
            tx_sr_r <= {1'b1, tx_sr_r[7:1]};
            tx_n_r <= 3'(tx_n_r + 3'h1);
         end
         unique case (cst_r)
            C_CMD: begin
               if (byte_done) begin
                  if (rx_byte == `LSM_CMD_WR) begin
                     crc_r <= crc_byte(`LSM_CRC_INIT, rx_byte);
                     cst_r <= C_WA1;
                  end else if (rx_byte == `LSM_CMD_RD) begin
                     crc_r <= crc_byte(`LSM_CRC_INIT, rx_byte);
                     tx_sr_r <= ta_lo_r;
                     tx_n_r <= 3'h0;
                     hdr_n_r <= 2'h0;
                     ptr_r <= ta_lo_r[4:0];
                     cst_r <= C_RHDR;
                  end else if (rx_byte == `LSM_CMD_CP) begin
                     cst_r <= C_CA1;
                  end else begin
                     cst_r <= C_HALT;
                  end
               end
            end
            C_WA1: begin
               if (byte_done) begin
                  ta_lo_r <= rx_byte;
                  crc_r <= crc_w;
                  cst_r <= C_WA2;
               end
            end
            C_WA2: begin
               if (byte_done) begin
                  ta_hi_r <= rx_byte;
                  crc_r <= crc_w;
                  ptr_r <= ta_lo_r[4:0];
                  pf_r <= 1'b0;
                  cst_r <= C_WDAT;
               end
            end
            C_WDAT: begin
               if (byte_done) begin
                  es_off_r <= ptr_r;
                  aa_r <= 1'b0;
                  crc_r <= crc_w;
                  if (ptr_r == `LSM_OFF_LAST) begin
                     tx_sr_r <= ~crc_w[7:0];
                     tx_n_r <= 3'h0;
                     crc_n_r <= 1'b0;
                     cst_r <= C_CRC;
                  end else begin
                     ptr_r <= 5'(ptr_r + 5'h01);
                  end
               end
            end
            C_RHDR: begin
               if (tx_last) begin
                  crc_r <= crc_tx;
                  hdr_n_r <= 2'(hdr_n_r + 2'h1);
                  if (hdr_n_r == 2'h0) begin
                     tx_sr_r <= ta_hi_r;
                  end else if (hdr_n_r == 2'h1) begin
                     tx_sr_r <= es_byte;
                  end else begin
                     tx_sr_r <= sp_r[ptr_r];
                     cst_r <= C_RDAT;
                  end
               end else if (rd_slot_i) begin
                  crc_r <= crc_tx;
               end
            end
            C_RDAT: begin
               if (rd_slot_i) begin
                  crc_r <= crc_tx;
               end
               if (tx_last) begin
                  if (ptr_r == `LSM_OFF_LAST) begin
                     tx_sr_r <= ~crc_tx[7:0];
                     crc_n_r <= 1'b0;
                     cst_r <= C_CRC;
                  end else begin
                     ptr_r <= 5'(ptr_r + 5'h01);
                     tx_sr_r <= sp_r[5'(ptr_r + 5'h01)];
                  end
               end
            end
            C_CRC: begin
               if (tx_last) begin
                  if (!crc_n_r) begin
                     tx_sr_r <= ~crc_r[15:8];
                     crc_n_r <= 1'b1;
                  end else begin
                     tx_sr_r <= `LSM_ONES;
                     cst_r <= C_ONES;
                  end
               end
            end
            C_ONES: begin
               if (tx_last) begin
                  tx_sr_r <= `LSM_ONES;
               end
            end
            C_CA1: begin
               if (byte_done) begin
                  auth_ok_r <= (rx_byte == ta_lo_r);
                  cst_r <= C_CA2;
               end
            end
            C_CA2: begin
               if (byte_done) begin
                  auth_ok_r <= auth_ok_r && (rx_byte == ta_hi_r);
                  cst_r <= C_CES;
               end
            end
            C_CES: begin
               if (byte_done) begin
                  if (auth_ok_r && rx_byte == es_byte && es_off_r == `LSM_OFF_LAST &&
                      !(mip_r && in_rng({ta_hi_r, ta_lo_r}, `LSM_REG_LO, `LSM_REG_HI))) begin
                     ptr_r <= ta_lo_r[4:0];
                     cst_r <= C_COPY;
                  end else begin
                     cst_r <= C_HALT;
                  end
               end
            end
            C_COPY: begin
               if (!int_busy_i) begin
                  cp_r.we <= 1'b1;
                  cp_r.addr <= {ta_hi_r, ta_lo_r[7:5], ptr_r};
                  cp_r.data <= sp_r[ptr_r];
                  if (ptr_r == es_off_r) begin
                     aa_r <= 1'b1;
                     tx_sr_r <= `LSM_ALT;
                     tx_n_r <= 3'h0;
                     cst_r <= C_ALT;
                  end else begin
                     ptr_r <= 5'(ptr_r + 5'h01);
                  end
               end
            end
            C_ALT: begin
               if (tx_last) begin
                  tx_sr_r <= `LSM_ALT;
               end
            end
            C_HALT: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Speed select and read path
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         od_r <= 1'b0;
      end else if (od_set_i) begin
         od_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ext_r <= `LSM_ZERO;
      end else if (in_rng(ext_addr_i, `LSM_PW_LO, `LSM_PW_HI)) begin
         ext_r <= `LSM_ZERO;
      end else begin
         ext_r <= ext_data_i;
      end
   end

   // ----------------------------------------
   // Mission time base
   // ----------------------------------------
   assign min_tick = sec_tick_i && (sec_n_r == `LSM_SEC_LAST);
   assign unit_tick = cfg_i.fast ? sec_tick_i : min_tick;
   // A rate of zero matches at 3FFFh, so samples come every 16384 units
   assign samp_tick = unit_tick && (per_n_r == 14'(cfg_i.rate - 14'h0001));

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sec_n_r <= 6'h00;
      end else if (min_tick) begin
         sec_n_r <= 6'h00;
      end else if (sec_tick_i) begin
         sec_n_r <= 6'(sec_n_r + 6'h01);
      end
   end

   // ----------------------------------------
   // Mission sequencing
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mst_r <= M_OFF;
         mip_r <= 1'b0;
         memory_cleared_flag_r <= 1'b0;
         stamp_r <= 1'b0;
         log_r <= 1'b0;
         meas_r <= 1'b0;
         per_n_r <= 14'h0000;
         dly_n_r <= 16'h0000;
      end else begin
         stamp_r <= 1'b0;
         log_r <= 1'b0;
         meas_r <= 1'b0;
         if (unit_tick) begin
            per_n_r <= samp_tick ? 14'h0000 : 14'(per_n_r + 14'h0001);
         end
         if (clr_mem_i && !mip_r) begin
            memory_cleared_flag_r <= 1'b1;
         end
         if (stop_cmd_i) begin
            mip_r <= 1'b0;
            mst_r <= M_OFF;
         end else begin
            unique case (mst_r)
               M_OFF: begin
                  if (start_cmd_i) begin
                     mip_r <= 1'b1;
                     memory_cleared_flag_r <= 1'b0;
                     dly_n_r <= 16'h0000;
                     mst_r <= M_DLY;
                  end
               end
               M_DLY: begin
                  if (dly_n_r == cfg_i.delay) begin
                     per_n_r <= 14'h0000;
                     if (!cfg_i.start_on_alarm) begin
                        stamp_r <= 1'b1;
                        log_r <= 1'b1;
                        mst_r <= M_RUN;
                     end else begin
                        mst_r <= M_WAIT;
                     end
                  end else if (min_tick) begin
                     dly_n_r <= 16'(dly_n_r + 16'h0001);
                  end
               end
               M_WAIT: begin
                  if (samp_tick && cfg_i.logging_enable) begin
                     meas_r <= 1'b1;
                     if (temp_alarm_i) begin
                        stamp_r <= 1'b1;
                        mst_r <= M_ARM;
                     end
                  end
               end
               M_ARM: begin
                  if (samp_tick) begin
                     log_r <= 1'b1;
                     mst_r <= M_RUN;
                  end
               end
               M_RUN: begin
                  if (samp_tick) begin
                     log_r <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mcnt_r <= '0;
         dcnt_r <= '0;
      end else begin
         if (clr_mem_i && !mip_r) begin
            mcnt_r <= '0;
         end else if (log_r) begin
            mcnt_r <= CNT_W'(mcnt_r + 1'b1);
         end
         if (log_r || meas_r) begin
            dcnt_r <= CNT_W'(dcnt_r + 1'b1);
         end
      end
   end

   assign rd_bit_o = tx_sr_r[0];
   assign overdrive_speed_sel_o = od_r;
   assign mission_active_o = mip_r;
   assign memory_cleared_flag_o = memory_cleared_flag_r;
   assign stamp_o = stamp_r;
   assign log_o = log_r;
   assign measure_o = meas_r;
   assign mission_cnt_o = mcnt_r;
   assign dev_cnt_o = dcnt_r;
   assign ext_data_o = ext_r;
   assign cp_o = cp_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   a_start_sets_mip: assert property (start_cmd_i && !stop_cmd_i && mst_r == M_OFF
      |=> mip_r && !memory_cleared_flag_r) else $error("start did not set mission");
   a_first_log: assert property (mst_r == M_DLY && dly_n_r == cfg_i.delay &&
      !cfg_i.start_on_alarm && !stop_cmd_i |=> log_r && stamp_r ##1 mcnt_r == $past(mcnt_r) + 1'b1)
      else $error("first entry missing");
   a_run_log: assert property (mst_r == M_RUN && samp_tick && !stop_cmd_i
      |=> log_r) else $error("run entry missing");
   a_wait_nolog: assert property (mst_r == M_WAIT |=> !log_r)
      else $error("logged while waiting for alarm");
   a_arm_log: assert property (mst_r == M_ARM && samp_tick && !stop_cmd_i
      |=> log_r ##1 dcnt_r == $past(dcnt_r) + 1'b1) else $error("armed entry missing");
   a_pw_zero: assert property (in_rng(ext_addr_i, `LSM_PW_LO, `LSM_PW_HI)
      |=> ext_r == `LSM_ZERO) else $error("password byte leaked");
   a_pf_partial: assert property (cst_r == C_WDAT && bus_rst_i && rx_n_r != 3'h0
      |=> pf_r && cst_r == C_CMD) else $error("partial byte flag not set");
   a_copy_end: assert property (cst_r == C_COPY |-> es_off_r == `LSM_OFF_LAST)
      else $error("copy with short ending offset");
   a_aa_write: assert property (cst_r == C_WDAT && byte_done && !bus_rst_i
      |=> !aa_r) else $error("accepted flag not cleared by write");
   a_ones_tail: assert property (cst_r == C_ONES && !bus_rst_i |=> rd_bit_o)
      else $error("tail bit not one");
   a_copy_yield: assert property (int_busy_i && !bus_rst_i |=> !cp_r.we)
      else $error("serial copy beat internal access");
   a_reg_page: assert property (cst_r == C_COPY |->
      !(mip_r && in_rng({ta_hi_r, ta_lo_r}, `LSM_REG_LO, `LSM_REG_HI)))
      else $error("register page copy in mission");

   c_alarm_start: cover property (mst_r == M_ARM ##[1:1000] log_r);
   c_copy_done: cover property (cst_r == C_COPY ##1 cst_r == C_ALT);
   c_read_crc: cover property (cst_r == C_RDAT ##1 cst_r == C_CRC);

endmodule

//--- bench/lsm_host.sv
// Purpose: Host side of the serial link
// Assumes: Bits and read slots are one-cycle pulses
// Notes: Released data line shows the inverse of the last bit
`timescale 1ns/1ps
module lsm_host (
   input wire logic clk_i,
   input wire logic rd_bit_i,
   output logic rx_vld_o,
   output logic rx_bit_o,
   output logic rd_slot_o,
   output logic bus_rst_o
);
   initial begin
      rx_vld_o = 1'b0;
      rx_bit_o = 1'b0;
      rd_slot_o = 1'b0;
      bus_rst_o = 1'b0;
   end
   // Bits LSB first, short count gives a partial byte
   task automatic put(input logic [7:0] b, input int n = 8);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         rx_vld_o <= 1'b1;
         rx_bit_o <= b[i];
         @(posedge clk_i);
         rx_vld_o <= 1'b0;
         rx_bit_o <= ~b[i];
      end
   endtask
   task automatic get(output logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         b[i] = rd_bit_i;
         rd_slot_o <= 1'b1;
         @(posedge clk_i);
         rd_slot_o <= 1'b0;
      end
   endtask
   task automatic brst();
      @(posedge clk_i);
      bus_rst_o <= 1'b1;
      @(posedge clk_i);
      bus_rst_o <= 1'b0;
   endtask
endmodule

//--- bench/test_logger_scratchpad_mission_ctl.sv
// Purpose: Self-checking bench of the scratchpad and mission logic
// Assumes: lsm_host drives the serial side
// Notes: Scenarios run in order after one reset
`timescale 1ns/1ps
module test_logger_scratchpad_mission_ctl;
   import lsm_pkg::*;
   logic clk_i, nrst_i, od_set_i, start_cmd_i, clr_mem_i, sec_tick_i;
   logic stop_cmd_i, temp_alarm_i, int_busy_i, meas_o;
   logic rx_vld, rx_bit, rd_slot, bus_rst, rd_bit_o, od_o, mip_o, mclr_o, stamp_o, log_o;
   logic [23:0] mcnt_o, dcnt_o;
   logic [15:0] ext_addr_i, crc;
   logic [7:0] ext_data_i, ext_data_o, v;
   lsm_cfg_t cfg_i;
   lsm_wr_t cp_o;
   int n_mismatch = 0;
   int checks = 0;
   int n_log = 0;
   int n_stamp = 0;
   int n_meas = 0;
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   lsm_host h (.clk_i(clk_i), .rd_bit_i(rd_bit_o), .rx_vld_o(rx_vld), .rx_bit_o(rx_bit),
      .rd_slot_o(rd_slot), .bus_rst_o(bus_rst));
   lsm_ctl dut (.clk_i(clk_i), .nrst_i(nrst_i), .bus_rst_i(bus_rst), .od_set_i(od_set_i),
      .rx_vld_i(rx_vld), .rx_bit_i(rx_bit), .rd_slot_i(rd_slot), .cfg_i(cfg_i),
      .start_cmd_i(start_cmd_i), .stop_cmd_i(stop_cmd_i), .clr_mem_i(clr_mem_i),
      .sec_tick_i(sec_tick_i), .temp_alarm_i(temp_alarm_i), .int_busy_i(int_busy_i),
      .ext_addr_i(ext_addr_i), .ext_data_i(ext_data_i), .rd_bit_o(rd_bit_o),
      .overdrive_speed_sel_o(od_o), .mission_active_o(mip_o), .memory_cleared_flag_o(mclr_o),
      .stamp_o(stamp_o), .log_o(log_o), .measure_o(meas_o), .mission_cnt_o(mcnt_o),
      .dev_cnt_o(dcnt_o), .ext_data_o(ext_data_o), .cp_o(cp_o));
   always @(posedge clk_i) begin
      if (log_o === 1'b1) n_log++;
      if (stamp_o === 1'b1) n_stamp++;
      if (meas_o === 1'b1) n_meas++;
   end
   task automatic chk(input logic [23:0] s, input logic [23:0] e);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic crc_upd(input logic [7:0] b);
      for (int i = 0; i < 8; i++) crc = (crc[0] ^ b[i]) ? ((crc >> 1) ^ 16'ha001) : (crc >> 1);
   endtask
   task automatic put_c(input logic [7:0] b);
      h.put(b);
      crc_upd(b);
   endtask
   task automatic get_c(input logic [7:0] e);
      h.get(v);
      chk(v, e);
      crc_upd(e);
   endtask
   task automatic tick();
      sec_tick_i <= 1'b1;
      @(posedge clk_i);
      sec_tick_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic crc_end();
      crc = ~crc;
      h.get(v);
      chk(v, crc[7:0]);
      h.get(v);
      chk(v, crc[15:8]);
      h.get(v);
      chk(v, 8'hff);
      h.brst();
   endtask
   task automatic hdr(input logic [7:0] c);
      crc = 16'h0000;
      put_c(c);
      put_c(8'h3c);
      put_c(8'h01);
   endtask
   task automatic stat(input logic [7:0] e);
      h.put(8'haa);
      h.get(v);
      h.get(v);
      h.get(v);
      chk(v, e);
      h.brst();
   endtask
   task automatic t_reset();
      @(posedge clk_i);
      chk(rd_bit_o, 1'b1);
      chk(od_o, 1'b0);
      od_set_i <= 1'b1;
      @(posedge clk_i);
      od_set_i <= 1'b0;
      @(posedge clk_i);
      chk(od_o, 1'b1);
      $display("t_reset done");
   endtask
   task automatic t_scratch();
      hdr(8'h0f);
      for (int i = 0; i < 4; i++) put_c(8'(8'ha0 + i));
      crc_end();
      crc = 16'h0000;
      put_c(8'haa);
      get_c(8'h3c);
      get_c(8'h01);
      get_c(8'h1f);
      for (int i = 0; i < 4; i++) get_c(8'(8'ha0 + i));
      crc_end();
      $display("t_scratch done");
   endtask
   task automatic t_copy();
      int n;
      n = 0;
      int_busy_i <= 1'b1;
      hdr(8'h99);
      h.put(8'h1f);
      for (int k = 0; k < 60; k++) begin
         @(posedge clk_i);
         if (k == 8) begin
            chk(n, 0);
            int_busy_i <= 1'b0;
         end
         if (cp_o.we === 1'b1) begin
            chk(cp_o.addr, 16'h013c + n);
            chk(cp_o.data, 8'ha0 + n);
            n++;
         end
      end
      chk(n, 4);
      h.get(v);
      chk(v, 8'h55);
      h.brst();
      stat(8'h9f);
      hdr(8'h0f);
      h.put(8'h5a);
      h.put(8'h07, 3);
      h.brst();
      stat(8'h3c);
      $display("t_copy done");
   endtask
   task automatic t_mission();
      clr_mem_i <= 1'b1;
      cfg_i.fast <= 1'b1;
      @(posedge clk_i);
      clr_mem_i <= 1'b0;
      start_cmd_i <= 1'b1;
      @(posedge clk_i);
      start_cmd_i <= 1'b0;
      @(posedge clk_i);
      chk(mip_o, 1'b1);
      chk(mclr_o, 1'b0);
      repeat (5) @(posedge clk_i);
      chk(n_stamp, 1);
      chk(n_log, 1);
      repeat (6) tick();
      chk(n_log, 4);
      chk(mcnt_o, 24'h000004);
      chk(dcnt_o, 24'h000004);
      ext_addr_i <= 16'h0228;
      repeat (2) @(posedge clk_i);
      chk(ext_data_o, 8'h00);
      ext_addr_i <= 16'h0100;
      repeat (2) @(posedge clk_i);
      chk(ext_data_o, 8'h5a);
      $display("t_mission done");
   endtask
   task automatic t_alarm();
      stop_cmd_i <= 1'b1;
      @(posedge clk_i);
      stop_cmd_i <= 1'b0;
      cfg_i.start_on_alarm <= 1'b1;
      cfg_i.logging_enable <= 1'b1;
      start_cmd_i <= 1'b1;
      @(posedge clk_i);
      start_cmd_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      n_log = 0;
      n_stamp = 0;
      repeat (4) tick();
      chk(n_meas, 2);
      chk(n_log, 0);
      chk(dcnt_o, 24'h000006);
      chk(mcnt_o, 24'h000004);
      temp_alarm_i <= 1'b1;
      repeat (2) tick();
      temp_alarm_i <= 1'b0;
      chk(n_stamp, 1);
      chk(n_log, 0);
      repeat (2) tick();
      chk(n_log, 1);
      chk(n_meas, 3);
      chk(mcnt_o, 24'h000005);
      chk(dcnt_o, 24'h000008);
      $display("t_alarm done");
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #200us;
      n_mismatch++;
      stop_test();
   end
   initial begin
      nrst_i = 1'b0;
      od_set_i = 1'b0;
      start_cmd_i = 1'b0;
      clr_mem_i = 1'b0;
      sec_tick_i = 1'b0;
      stop_cmd_i = 1'b0;
      temp_alarm_i = 1'b0;
      int_busy_i = 1'b0;
      ext_addr_i = 16'h0000;
      ext_data_i = 8'h5a;
      cfg_i = '0;
      cfg_i.rate = 14'h0002;
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_reset();
      t_scratch();
      t_copy();
      t_mission();
      t_alarm();
      stop_test();
   end
endmodule
